// ---- rtl/sccfg_map.svh ----
// Register offsets, field positions, reset values and timing figures of the sensor
// configuration bank. Assumes inclusion by bare name from the package and the module.
`ifndef SCCFG_MAP_SVH
`define SCCFG_MAP_SVH

// Register offsets
`define SCCFG_ADDR_STATUS 8'h11
`define SCCFG_ADDR_INT_CTRL 8'h19
`define SCCFG_ADDR_INTERFACE_CONFIG 8'h1a
`define SCCFG_ADDR_PWR 8'h1b
`define SCCFG_ADDR_OSR 8'h1c
`define SCCFG_ADDR_ODR 8'h1d
`define SCCFG_ADDR_FILT 8'h1f
`define SCCFG_ADDR_CMD 8'h7e

// Soft reset command code
`define SCCFG_CMD_SOFTRESET 8'hb6

// Writable bit masks, unassigned bits stay zero
`define SCCFG_MASK_INT_CTRL 8'h5f
`define SCCFG_MASK_INTERFACE_CONFIG 8'h07
`define SCCFG_MASK_PWR 8'h33
`define SCCFG_MASK_OSR 8'h3f
`define SCCFG_MASK_ODR 8'h1f
`define SCCFG_MASK_FILT 8'h0e

// Reset values
`define SCCFG_RST_INT_CTRL 8'h02
`define SCCFG_RST_INTERFACE_CONFIG 8'h00
`define SCCFG_RST_PWR 8'h00
`define SCCFG_RST_OSR 8'h00
`define SCCFG_RST_ODR 8'h00
`define SCCFG_RST_FILT 8'h00

// Interrupt control fields
`define SCCFG_IC_OD 0
`define SCCFG_IC_LEVEL 1
`define SCCFG_IC_LATCH 2
`define SCCFG_IC_FWM_EN 3
`define SCCFG_IC_FFULL_EN 4
`define SCCFG_IC_DRDY_EN 6

// Interface config fields
`define SCCFG_IF_WIRE3 0
`define SCCFG_IF_WDT_EN 1
`define SCCFG_IF_WDT_SEL 2

// Power control fields
`define SCCFG_PWR_PRESS 0
`define SCCFG_PWR_TEMP 1
`define SCCFG_PWR_MODE_HI 5
`define SCCFG_PWR_MODE_LO 4
`define SCCFG_MODE_SLEEP 2'h0
`define SCCFG_MODE_NORMAL 2'h3

// Status flag positions
`define SCCFG_ST_FWM 0
`define SCCFG_ST_FFULL 1
`define SCCFG_ST_DRDY 3

// Rate subdivision ceiling and base period
`define SCCFG_ODR_MAX 5'h11
`define SCCFG_ODR_BASE_US 5000

// Timing, in nanoseconds, and watchdog counter width in bits
`define SCCFG_MCLK_NS 25
`define SCCFG_WDT_SHORT_NS 1250000
`define SCCFG_WDT_LONG_NS 40000000
`define SCCFG_WD_CNT_W 21

`endif

// ---- rtl/sccfg_pkg.sv ----
// Types shared by the sensor configuration bank.
// Assumes sccfg_map.svh is on the include path.
`include "sccfg_map.svh"

package sccfg_pkg;

  // Register port request from the serial protocol engine
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } sccfg_regbus_t;

  // Event pulses from the measurement engine and FIFO
  typedef struct packed {
    logic fwm;
    logic ffull;
    logic drdy;
  } sccfg_evt_t;

  // Configuration registers as seen by the rest of the chip
  typedef struct packed {
    logic [7:0] int_ctrl;
    logic [7:0] interface_config;
    logic [7:0] pwr;
    logic [7:0] osr;
    logic [7:0] odr;
    logic [7:0] filt;
  } sccfg_cfg_t;

  // Bus watchdog states
  typedef enum logic [2:0] {
    SCCFG_WD_IDLE = 3'b001,
    SCCFG_WD_RUN = 3'b010,
    SCCFG_WD_TRIP = 3'b100
  } sccfg_wd_t;

  // Whole state of the bank
  typedef struct packed {
    sccfg_cfg_t cfg;
    logic [7:0] status;
    logic int_act;
    logic int_out;
    logic int_oe;
    logic [7:0] rdata;
    logic rvalid;
    logic nvm_pend;
    logic scl_s1;
    logic scl_s2;
    logic scl_s3;
    sccfg_wd_t wd;
    logic [`SCCFG_WD_CNT_W-1:0] wd_cnt;
    logic wd_trip;
  } sccfg_state_t;

endpackage

// ---- rtl/sccfg_regs.sv ----
// Configuration register bank of a pressure and temperature sensor, with the
// interrupt pin driver, interrupt status flags and the two-wire bus watchdog.
// Assumes a serial protocol engine on i_mclk presents register accesses, and that
// the measurement engine and FIFO give one-cycle event pulses on i_mclk.
`timescale 1ns/1ps
`include "sccfg_map.svh"

// Functional notes
// - Interrupt bit 0 picks push-pull or open-drain
// - Interrupt bit 1 sets pin active level
// - Interrupt bit 2 latches pin to status flags
// - Interrupt bit 3 gates watermark event
// - Interrupt bit 4 gates FIFO full event
// - Interrupt bit 6 gates sample ready event
// - Interface bit 0 selects three-wire serial
// - Interface bit 1 enables watchdog, NVM default
// - Interface bit 2 picks 1.25 or 40 ms
// - Power bit 0 enables pressure sensing
// - Power bit 1 enables temperature sensing
// - Mode field: sleep, forced, normal
// - Oversampling fields for pressure and temperature
// - Rate field saturates at seventeen
// - Rate zero is 5 ms, doubling upward
// - Filter field selects recursive coefficient
// - Status flags bits 0,1,3, clear on read
// - Soft reset command restores configuration defaults, status kept
module sccfg_regs #(
  parameter int WDT_SHORT_CYC = `SCCFG_WDT_SHORT_NS / `SCCFG_MCLK_NS,
  parameter int WDT_LONG_CYC = `SCCFG_WDT_LONG_NS / `SCCFG_MCLK_NS
) (
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic i_ce,
  input wire sccfg_pkg::sccfg_regbus_t i_bus,
  input wire sccfg_pkg::sccfg_evt_t i_evt,
  input wire logic i_meas_done,
  input wire logic i_nvm_wdt_en,
  input wire logic i_nvm_wdt_sel,
  input wire logic i_scl,
  input wire logic i_i2c_busy,
  output logic [7:0] o_rdata,
  output logic o_rvalid,
  output sccfg_pkg::sccfg_cfg_t o_cfg,
  output logic [7:0] o_status,
  output logic o_int_out,
  output logic o_int_oe,
  output logic o_wdt_trip
);
  import sccfg_pkg::*;

  // Refuse counts the watchdog counter cannot hold
  if (WDT_SHORT_CYC < 1 || WDT_LONG_CYC < 1 ||
      WDT_SHORT_CYC >= (1 << `SCCFG_WD_CNT_W) ||
      WDT_LONG_CYC >= (1 << `SCCFG_WD_CNT_W)) begin : g_chk
    $error("sccfg_regs: watchdog count out of range");
  end

  localparam sccfg_cfg_t CFG_DEF = '{
    int_ctrl: `SCCFG_RST_INT_CTRL, interface_config: `SCCFG_RST_INTERFACE_CONFIG,
    pwr: `SCCFG_RST_PWR, osr: `SCCFG_RST_OSR,
    odr: `SCCFG_RST_ODR, filt: `SCCFG_RST_FILT};

  // Writable bits of every register
  localparam sccfg_cfg_t CFG_MASK = '{
    int_ctrl: `SCCFG_MASK_INT_CTRL, interface_config: `SCCFG_MASK_INTERFACE_CONFIG,
    pwr: `SCCFG_MASK_PWR, osr: `SCCFG_MASK_OSR,
    odr: `SCCFG_MASK_ODR, filt: `SCCFG_MASK_FILT};

  // Bus clock history starts at the pulled-up idle level, no false edge
  localparam sccfg_state_t ST_RST = '{
    cfg: CFG_DEF, wd: SCCFG_WD_IDLE, nvm_pend: 1'b1, int_oe: 1'b1,
    scl_s1: 1'b1, scl_s2: 1'b1, scl_s3: 1'b1, default: '0};

  localparam logic [`SCCFG_WD_CNT_W-1:0] WD_SHORT_M1 = `SCCFG_WD_CNT_W'(WDT_SHORT_CYC - 1);
  localparam logic [`SCCFG_WD_CNT_W-1:0] WD_LONG_M1 = `SCCFG_WD_CNT_W'(WDT_LONG_CYC - 1);

  sccfg_state_t st;
  sccfg_state_t next_st;
  logic [7:0] evt_g;
  logic stat_clr;
  logic scl_edge;
  logic forced;
  logic [1:0] mode_now;
  logic [`SCCFG_WD_CNT_W-1:0] wd_lim;

  // Next state of the whole bank
  always_comb begin
    next_st = st;
    evt_g = 8'h00;
    stat_clr = 1'b0;
    scl_edge = st.scl_s2 ^ st.scl_s3;
    mode_now = st.cfg.pwr[`SCCFG_PWR_MODE_HI:`SCCFG_PWR_MODE_LO];
    forced = (mode_now != `SCCFG_MODE_SLEEP) && (mode_now != `SCCFG_MODE_NORMAL);
    wd_lim = st.cfg.interface_config[`SCCFG_IF_WDT_SEL] ? WD_LONG_M1 : WD_SHORT_M1;
    if (i_ce) begin
      next_st.rvalid = 1'b0;
      next_st.wd_trip = 1'b0;

      // Read mux, old status value returned before its clear
      if (i_bus.rd) begin
        next_st.rvalid = 1'b1;
        case (i_bus.addr)
          `SCCFG_ADDR_STATUS: next_st.rdata = st.status;
          `SCCFG_ADDR_INT_CTRL: next_st.rdata = st.cfg.int_ctrl;
          `SCCFG_ADDR_INTERFACE_CONFIG: next_st.rdata = st.cfg.interface_config;
          `SCCFG_ADDR_PWR: next_st.rdata = st.cfg.pwr;
          `SCCFG_ADDR_OSR: next_st.rdata = st.cfg.osr;
          `SCCFG_ADDR_ODR: next_st.rdata = st.cfg.odr;
          `SCCFG_ADDR_FILT: next_st.rdata = st.cfg.filt;
          default: next_st.rdata = 8'h00;
        endcase
      end

      // Gated events; set wins over clear on read
      evt_g[`SCCFG_ST_FWM] = i_evt.fwm & st.cfg.int_ctrl[`SCCFG_IC_FWM_EN];
      evt_g[`SCCFG_ST_FFULL] = i_evt.ffull & st.cfg.int_ctrl[`SCCFG_IC_FFULL_EN];
      evt_g[`SCCFG_ST_DRDY] = i_evt.drdy & st.cfg.int_ctrl[`SCCFG_IC_DRDY_EN];
      stat_clr = i_bus.rd && (i_bus.addr == `SCCFG_ADDR_STATUS);
      next_st.status = (stat_clr ? 8'h00 : st.status) | evt_g;

      // Forced measurement done, back to sleep
      if (forced && i_meas_done) begin
        next_st.cfg.pwr[`SCCFG_PWR_MODE_HI:`SCCFG_PWR_MODE_LO] = `SCCFG_MODE_SLEEP;
      end

      // Watchdog defaults loaded from NVM after reset
      if (st.nvm_pend) begin
        next_st.cfg.interface_config[`SCCFG_IF_WDT_EN] = i_nvm_wdt_en;
        next_st.cfg.interface_config[`SCCFG_IF_WDT_SEL] = i_nvm_wdt_sel;
        next_st.nvm_pend = 1'b0;
      end

      // Register writes, unassigned bits masked off
      if (i_bus.wr) begin
        case (i_bus.addr)
          `SCCFG_ADDR_INT_CTRL: begin
            next_st.cfg.int_ctrl = i_bus.wdata & `SCCFG_MASK_INT_CTRL;
          end
          `SCCFG_ADDR_INTERFACE_CONFIG: begin
            next_st.cfg.interface_config = i_bus.wdata & `SCCFG_MASK_INTERFACE_CONFIG;
          end
          `SCCFG_ADDR_PWR: begin
            next_st.cfg.pwr = i_bus.wdata & `SCCFG_MASK_PWR;
          end
          `SCCFG_ADDR_OSR: begin
            next_st.cfg.osr = i_bus.wdata & `SCCFG_MASK_OSR;
          end
          `SCCFG_ADDR_ODR: begin
            // Period is the 5 ms base times two to the stored value
            if (i_bus.wdata[4:0] > `SCCFG_ODR_MAX) begin
              next_st.cfg.odr = {3'h0, `SCCFG_ODR_MAX};
            end else begin
              next_st.cfg.odr = i_bus.wdata & `SCCFG_MASK_ODR;
            end
          end
          `SCCFG_ADDR_FILT: begin
            next_st.cfg.filt = i_bus.wdata & `SCCFG_MASK_FILT;
          end
          `SCCFG_ADDR_CMD: begin
            if (i_bus.wdata == `SCCFG_CMD_SOFTRESET) begin
              next_st.cfg = CFG_DEF;
              next_st.nvm_pend = 1'b1;
            end
          end
          default: begin
          end
        endcase
      end

      // Pin activity: held by status when latched, else follows events
      if (next_st.cfg.int_ctrl[`SCCFG_IC_LATCH]) begin
        next_st.int_act = |next_st.status;
      end else begin
        next_st.int_act = |evt_g;
      end

      // Pin drive and polarity
      if (!next_st.cfg.int_ctrl[`SCCFG_IC_OD]) begin
        next_st.int_oe = 1'b1;
        next_st.int_out = next_st.cfg.int_ctrl[`SCCFG_IC_LEVEL] ?
          next_st.int_act : ~next_st.int_act;
      end else begin
        next_st.int_out = 1'b0;
        next_st.int_oe = next_st.cfg.int_ctrl[`SCCFG_IC_LEVEL] ?
          ~next_st.int_act : next_st.int_act;
      end

      // Clock line synchroniser and edge history
      next_st.scl_s1 = i_scl;
      next_st.scl_s2 = st.scl_s1;
      next_st.scl_s3 = st.scl_s2;

      // Bus watchdog: trips when the clock line stalls mid transfer
      case (st.wd)
        SCCFG_WD_IDLE: begin
          next_st.wd_cnt = '0;
          if (st.cfg.interface_config[`SCCFG_IF_WDT_EN] && i_i2c_busy) begin
            next_st.wd = SCCFG_WD_RUN;
          end
        end
        SCCFG_WD_RUN: begin
          if (!st.cfg.interface_config[`SCCFG_IF_WDT_EN] || !i_i2c_busy) begin
            next_st.wd = SCCFG_WD_IDLE;
            next_st.wd_cnt = '0;
          end else if (scl_edge) begin
            next_st.wd_cnt = '0;
          end else if (st.wd_cnt >= wd_lim) begin
            next_st.wd_trip = 1'b1;
            next_st.wd = SCCFG_WD_TRIP;
            next_st.wd_cnt = '0;
          end else begin
            next_st.wd_cnt = st.wd_cnt + 1'b1;
          end
        end
        SCCFG_WD_TRIP: begin
          if (!i_i2c_busy) begin
            next_st.wd = SCCFG_WD_IDLE;
          end
        end
        default: begin
          next_st.wd = SCCFG_WD_IDLE;
          next_st.wd_cnt = '0;
        end
      endcase
    end
  end

  // State register
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      st <= ST_RST;
    end else begin
      st <= next_st;
    end
  end

  // Outputs straight from the state
  assign o_rdata = st.rdata;
  assign o_rvalid = st.rvalid;
  assign o_cfg = st.cfg;
  assign o_status = st.status;
  assign o_int_out = st.int_out;
  assign o_int_oe = st.int_oe;
  assign o_wdt_trip = st.wd_trip;

  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (i_rst);

  // Push-pull always drives the pin
  drive_select_a: assert property (!o_cfg.int_ctrl[`SCCFG_IC_OD] |-> o_int_oe)
    else $error("push-pull pin not driven");

  // Latched push-pull level shows whether any flag is up
  pin_level_a: assert property (o_cfg.int_ctrl[`SCCFG_IC_LATCH] &&
    !o_cfg.int_ctrl[`SCCFG_IC_OD] |-> o_int_out == (o_cfg.int_ctrl[`SCCFG_IC_LEVEL] ?
    (|o_status) : !(|o_status)))
    else $error("pin level disagrees with polarity");

  // Latched pin holds until the status read
  latch_hold_a: assert property (i_ce && st.int_act && !i_bus.rd && !i_bus.wr &&
    o_cfg.int_ctrl[`SCCFG_IC_LATCH] |=> st.int_act)
    else $error("latched interrupt dropped");

  // Disabled watermark never sets its flag
  fwm_gate_a: assert property (i_ce && i_evt.fwm && !o_status[`SCCFG_ST_FWM] &&
    !o_cfg.int_ctrl[`SCCFG_IC_FWM_EN] |=> !o_status[`SCCFG_ST_FWM])
    else $error("gated watermark flag set");

  // Enabled full event sets its flag even during a clear
  ffull_set_a: assert property (i_ce && i_evt.ffull &&
    o_cfg.int_ctrl[`SCCFG_IC_FFULL_EN] |=> o_status[`SCCFG_ST_FFULL])
    else $error("full flag lost");

  // Enabled sample ready sets its flag
  drdy_set_a: assert property (i_ce && i_evt.drdy &&
    o_cfg.int_ctrl[`SCCFG_IC_DRDY_EN] |=> o_status[`SCCFG_ST_DRDY])
    else $error("sample ready flag lost");

  // Three-wire bit takes the written value
  wire_sel_a: assert property (i_ce && i_bus.wr &&
    i_bus.addr == `SCCFG_ADDR_INTERFACE_CONFIG |=> o_cfg.interface_config[`SCCFG_IF_WIRE3] ==
    $past(i_bus.wdata[`SCCFG_IF_WIRE3]))
    else $error("three-wire bit not written");

  // Watchdog trip needs the enable
  wdt_enable_a: assert property (o_wdt_trip |->
    $past(o_cfg.interface_config[`SCCFG_IF_WDT_EN]))
    else $error("watchdog tripped while disabled");

  // Pressure enable takes the written bit
  press_enable_a: assert property (i_ce && i_bus.wr &&
    i_bus.addr == `SCCFG_ADDR_PWR |=> o_cfg.pwr[`SCCFG_PWR_PRESS] ==
    $past(i_bus.wdata[`SCCFG_PWR_PRESS]))
    else $error("pressure enable not written");

  // Temperature enable takes the written bit
  temp_enable_a: assert property (i_ce && i_bus.wr &&
    i_bus.addr == `SCCFG_ADDR_PWR |=> o_cfg.pwr[`SCCFG_PWR_TEMP] ==
    $past(i_bus.wdata[`SCCFG_PWR_TEMP]))
    else $error("temperature enable not written");

  // Status read with no events empties the flags
  clear_read_a: assert property (i_ce && i_bus.rd && !i_evt.fwm &&
    !i_evt.ffull && !i_evt.drdy && i_bus.addr == `SCCFG_ADDR_STATUS |=> o_status == 8'h00)
    else $error("status not cleared by read");

  // Rate field never exceeds seventeen
  rate_sat_a: assert property (o_cfg.odr <= {3'h0, `SCCFG_ODR_MAX})
    else $error("rate field above ceiling");

  // Unassigned bits of every register stay zero
  unused_zero_a: assert property ((o_cfg & ~CFG_MASK) == '0)
    else $error("unassigned bit set");

  // Soft reset brings every default next cycle
  soft_reset_a: assert property (i_ce && i_bus.wr &&
    i_bus.addr == `SCCFG_ADDR_CMD && i_bus.wdata == `SCCFG_CMD_SOFTRESET |=> o_cfg == CFG_DEF)
    else $error("soft reset did not restore");

  // Forced measurement end returns to sleep
  forced_sleep_a: assert property (i_ce && forced && i_meas_done && !i_bus.wr |=>
    o_cfg.pwr[`SCCFG_PWR_MODE_HI:`SCCFG_PWR_MODE_LO] == `SCCFG_MODE_SLEEP)
    else $error("forced mode did not return to sleep");

  // Every read answered the next cycle, pulse held only while frozen
  read_answer_a: assert property (i_ce && i_bus.rd |=> o_rvalid ##1
    (!o_rvalid || $past(i_bus.rd) || !$past(i_ce)))
    else $error("read not answered");

endmodule

// ---- test/sccfg_host.sv ----
// Host-side model of the two-wire bus: marks a transfer busy and toggles the bus clock.
// Assumes the bench raises i_go to start a transfer and lowers it to end one.
`timescale 1ns/1ps

module sccfg_host (
  input wire logic i_go,
  output logic o_scl,
  output logic o_busy
);
  // Pulled-up bus clock idles high outside transfers
  initial begin
    o_scl = 1'b1;
    o_busy = 1'b0;
  end

  // Start of transfer: six clock edges at 200 ns period, then the host stalls
  always @(posedge i_go) begin
    #37 o_busy = 1'b1;
    repeat (6) #100 o_scl = ~o_scl;
  end

  // End of transfer releases the bus
  always @(negedge i_go) begin
    o_busy = 1'b0;
    o_scl = 1'b1;
  end
endmodule

// ---- test/sccfg_regs_test.sv ----
// Self-checking bench for the sensor configuration bank.
// Assumes the design with short watchdog counts and the host model beside it.
`timescale 1ns/1ps
`include "sccfg_map.svh"

module sccfg_regs_test;
  import sccfg_pkg::*;
  logic i_mclk = 1'b0;
  logic i_rst = 1'b1;
  logic i_meas_done = 1'b0;
  logic go = 1'b0;
  logic ce = 1'b1;
  logic nvm_en = 1'b1;
  logic nvm_sel = 1'b0;
  sccfg_regbus_t i_bus = '0;
  sccfg_evt_t i_evt = '0;
  logic scl;
  logic busy;
  logic [7:0] o_rdata;
  logic [7:0] o_status;
  logic o_rvalid;
  logic o_int_out;
  logic o_int_oe;
  logic o_wdt_trip;
  sccfg_cfg_t o_cfg;
  logic [7:0] exp_q[$];
  int err_count = 0;
  int checks_done = 0;
  int trips = 0;
  localparam logic [7:0] ADDRS [6] = '{8'h19, 8'h1a, 8'h1b, 8'h1c, 8'h1d, 8'h1f};
  localparam logic [7:0] MASKS [6] = '{8'h5f, 8'h07, 8'h33, 8'h3f, 8'h1f, 8'h0e};
  localparam logic [7:0] RSTV [6] = '{8'h02, 8'h02, 8'h00, 8'h00, 8'h00, 8'h00};

  // 40 MHz clock
  always #12.5 i_mclk = ~i_mclk;

  sccfg_regs #(.WDT_SHORT_CYC(20), .WDT_LONG_CYC(60)) i_dut (
    .i_mclk(i_mclk), .i_rst(i_rst), .i_ce(ce), .i_bus(i_bus), .i_evt(i_evt),
    .i_meas_done(i_meas_done), .i_nvm_wdt_en(nvm_en), .i_nvm_wdt_sel(nvm_sel),
    .i_scl(scl), .i_i2c_busy(busy), .o_rdata(o_rdata), .o_rvalid(o_rvalid),
    .o_cfg(o_cfg), .o_status(o_status), .o_int_out(o_int_out), .o_int_oe(o_int_oe),
    .o_wdt_trip(o_wdt_trip)
  );

  sccfg_host i_host (.i_go(go), .o_scl(scl), .o_busy(busy));

  task automatic summarize();
    if (err_count == 0 && checks_done > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task automatic cmp_byte(string what, logic [7:0] exp, logic [7:0] got);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic cmp_bit(string what, logic exp, logic got);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %s expected %b seen %b", what, exp, got);
    end
  endtask

  // Register write, held for one enabled edge
  task automatic wr(logic [7:0] a, logic [7:0] d);
    @(negedge i_mclk);
    i_bus.wr = 1'b1;
    i_bus.addr = a;
    i_bus.wdata = d;
    @(negedge i_mclk);
    i_bus.wr = 1'b0;
  endtask

  // Register read, expected byte noted for the monitor
  task automatic rd(logic [7:0] a, logic [7:0] e);
    @(negedge i_mclk);
    i_bus.rd = 1'b1;
    i_bus.addr = a;
    exp_q.push_back(e);
    @(negedge i_mclk);
    i_bus.rd = 1'b0;
  endtask

  // One-cycle event pulse
  task automatic ev(logic [2:0] e);
    @(negedge i_mclk);
    i_evt = e;
    @(negedge i_mclk);
    i_evt = '0;
  endtask

  task automatic meas_done();
    @(negedge i_mclk);
    i_meas_done = 1'b1;
    @(negedge i_mclk);
    i_meas_done = 1'b0;
  endtask

  // Monitor: each read answer against the oldest note, and watchdog pulses
  always @(negedge i_mclk) begin
    if (o_wdt_trip === 1'b1) trips++;
    if (o_rvalid === 1'b1) begin
      if (exp_q.size() > 0) cmp_byte("read data", exp_q.pop_front(), o_rdata);
      else cmp_byte("read count", 8'h00, 8'h01);
    end
  end

  // Watchdog against a hang
  initial begin
    #200us;
    err_count++;
    summarize();
  end

  initial begin
    logic [7:0] d;
    logic [7:0] e;
    void'($urandom(32'h5a7dbfc0));
    repeat (6) @(posedge i_mclk);
    @(negedge i_mclk);
    i_rst = 1'b0;
    // Reset values, watchdog bits from the NVM levels
    for (int i = 0; i < 6; i++) rd(ADDRS[i], RSTV[i]);
    // Random writes, unassigned bits dropped, rate field saturated
    repeat (4) for (int i = 0; i < 6; i++) begin
      d = 8'($urandom);
      e = d & MASKS[i];
      if (i == 4 && e > 8'h11) e = 8'h11;
      wr(ADDRS[i], d);
      rd(ADDRS[i], e);
    end
    foreach (ADDRS[i]) begin
      wr(8'h1d, 8'h10 + 8'(i));
      rd(8'h1d, (i < 2) ? 8'h10 + 8'(i) : 8'h11);
    end
    for (int c = 0; c < 8; c++) begin
      wr(8'h1f, 8'(c << 1) | 8'hf1);
      rd(8'h1f, 8'(c << 1));
      wr(8'h1c, 8'(c % 6) * 8'h09);
      rd(8'h1c, 8'(c % 6) * 8'h09);
    end
    for (int m = 0; m < 4; m++) begin
      wr(8'h1b, 8'(m << 4) | 8'(m));
      cmp_bit("pressure enable", m[0], o_cfg.pwr[0]);
      cmp_bit("temperature enable", m[1], o_cfg.pwr[1]);
      rd(8'h1b, 8'(m << 4) | 8'(m));
    end
    wr(8'h20, 8'hff);
    rd(8'h20, 8'h00);
    rd(8'h7e, 8'h00);
    // Latched events, active-high push-pull pin
    wr(8'h19, 8'h5e);
    rd(8'h11, 8'h00);
    ev(3'b111);
    cmp_bit("pin level", 1'b1, o_int_out);
    cmp_bit("pin enable", 1'b1, o_int_oe);
    cmp_byte("status", 8'h0b, o_status);
    rd(8'h11, 8'h0b);
    rd(8'h11, 8'h00);
    cmp_bit("pin cleared", 1'b0, o_int_out);
    // Each event source gated off in turn
    for (int k = 0; k < 3; k++) begin
      wr(8'h19, 8'h5e & ~(k == 0 ? 8'h08 : k == 1 ? 8'h10 : 8'h40));
      ev(3'b111);
      rd(8'h11, 8'h0b & ~(k == 0 ? 8'h01 : k == 1 ? 8'h02 : 8'h08));
    end
    // Unlatched pin gives a single-cycle pulse
    wr(8'h4a, 8'h00);
    wr(8'h19, 8'h4a);
    ev(3'b001);
    cmp_bit("pulse high", 1'b1, o_int_out);
    @(negedge i_mclk);
    cmp_bit("pulse end", 1'b0, o_int_out);
    rd(8'h11, 8'h08);
    // Open-drain active-low pin
    wr(8'h19, 8'h45);
    ev(3'b001);
    cmp_bit("od active oe", 1'b1, o_int_oe);
    cmp_bit("od active out", 1'b0, o_int_out);
    rd(8'h11, 8'h08);
    repeat (2) @(negedge i_mclk);
    cmp_bit("od released", 1'b0, o_int_oe);
    wr(8'h19, 8'h44);
    cmp_bit("idle low-active", 1'b1, o_int_out);
    // Forced mode falls back to sleep, normal mode stays
    wr(8'h1b, 8'h13);
    meas_done();
    rd(8'h1b, 8'h03);
    wr(8'h1b, 8'h23);
    meas_done();
    rd(8'h1b, 8'h03);
    wr(8'h1b, 8'h33);
    meas_done();
    rd(8'h1b, 8'h33);
    // Other commands change nothing; soft reset reloads defaults and new NVM levels
    wr(8'h7e, 8'hb0);
    rd(8'h1b, 8'h33);
    nvm_en = 1'b0;
    nvm_sel = 1'b1;
    wr(8'h7e, 8'hb6);
    repeat (2) @(negedge i_mclk);
    for (int i = 0; i < 6; i++) rd(ADDRS[i], (i == 1) ? 8'h04 : RSTV[i]);
    // Clock enable low: a write is not taken
    @(negedge i_mclk);
    ce = 1'b0;
    wr(8'h1f, 8'h0e);
    ce = 1'b1;
    cmp_byte("frozen filter", 8'h00, o_cfg.filt);
    rd(8'h1f, 8'h00);
    // Watchdog off, short period and long period with a stalled host
    for (int k = 0; k < 3; k++) begin
      wr(8'h1a, k == 0 ? 8'h00 : k == 1 ? 8'h02 : 8'h06);
      trips = 0;
      go = 1'b1;
      repeat (62) @(negedge i_mclk);
      cmp_byte("early trips", (k == 1) ? 8'h01 : 8'h00, 8'(trips));
      repeat (140) @(negedge i_mclk);
      cmp_byte("trips", (k == 0) ? 8'h00 : 8'h01, 8'(trips));
      go = 1'b0;
      repeat (4) @(negedge i_mclk);
    end
    repeat (4) @(negedge i_mclk);
    cmp_byte("reads left", 8'h00, 8'(exp_q.size()));
    summarize();
  end
endmodule
